// ---- hw/change_sense_pin_pkg.sv ----
// Package for the pin change interrupt unit: register map, field layout, types.
// Assumes a 32-bit Avalon-MM slave with byte addressing, word-aligned registers.
package change_sense_pin_pkg;

  // ------------------------------------------------------------
  // Register indices and address width
  // ------------------------------------------------------------
  localparam logic [7:0]  IDX_GROUP0_PIN_MASK = 8'h6b;
  localparam logic [7:0]  IDX_GROUP1_PIN_MASK = 8'h6c;
  localparam logic [7:0]  IDX_GROUP2_PIN_MASK = 8'h6d;
  localparam logic [7:0]  IDX_GROUP3_PIN_MASK = 8'h73;
  localparam logic [7:0]  IDX_PIN_CHANGE_FLAGS = 8'h74;
  localparam logic [7:0]  IDX_GROUP_ENABLE    = 8'h75;
  localparam logic [7:0]  IDX_GLOBAL_ENABLE   = 8'h76;
  localparam logic [7:0]  IDX_IRQ_STATUS      = 8'h77;
  localparam logic [7:0]  IDX_IRQ_MASK        = 8'h78;
  localparam logic [7:0]  IDX_VECTOR_TAKEN    = 8'h79;
  localparam int          ADDR_W              = 10;

  // ------------------------------------------------------------
  // Widths and reset values
  // ------------------------------------------------------------
  localparam int          GROUPS              = 4;
  localparam int          PINS_PER_GROUP      = 8;
  localparam int          PINS                = GROUPS * PINS_PER_GROUP;
  localparam logic [7:0]  MASK_RESET          = 8'h00;
  localparam logic [3:0]  FLAG_RESET          = 4'h0;
  localparam logic [31:0] UNMAPPED_READ       = 32'h0000_0000;
  localparam int          GLOBAL_EN_BIT       = 0;

  // ------------------------------------------------------------
  // Types
  // ------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [3:0]        byteenable;
    logic [31:0]       writedata;
  } change_sense_pin_avm_req_t;

  typedef enum logic [1:0] {
    BUS_IDLE,
    BUS_ACK
  } change_sense_pin_bus_state_t;

endpackage : change_sense_pin_pkg

// ---- hw/change_sense_pin_sync3.sv ----
// Three-stage synchroniser with change detect for one pin.
// Assumes pin is asynchronous to core_clk_i.
`timescale 1ns/1ns
module change_sense_pin_sync3 (
  input  wire logic core_clk_i,
  input  wire logic arst_n_i,
  input  wire logic pin_i,
  output logic      level_o,
  output logic      change_o
);
  logic meta_q;
  logic s2_q;
  logic s3_q;

  // ------------------------------------------------------------
  // Sampling chain
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= 1'b0;
      s2_q   <= 1'b0;
      s3_q   <= 1'b0;
    end else begin
      meta_q <= pin_i;
      s2_q   <= meta_q;
      s3_q   <= s2_q;
    end
  end

  // Level settled once stages two and three agree
  logic level_q;
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      level_q <= 1'b0;
    end else if (s2_q == s3_q) begin
      level_q <= s3_q;
    end
  end

  assign level_o  = level_q;
  assign change_o = (s2_q == s3_q) && (s3_q != level_q);
endmodule : change_sense_pin_sync3

// ---- hw/change_sense_pin_group.sv ----
// One group of eight pins: mask, change detect and sticky flag.
// Assumes masks and clear strobes come from the register file on the same clock.
`timescale 1ns/1ns
module change_sense_pin_group
  import change_sense_pin_pkg::*;
(
  input  wire logic                      core_clk_i,
  input  wire logic                      arst_n_i,
  input  wire logic [PINS_PER_GROUP-1:0] pins_i,
  input  wire logic [PINS_PER_GROUP-1:0] mask_i,
  input  wire logic                      group_en_i,
  input  wire logic                      clear_i,
  output logic                           flag_o,
  output logic                           set_o
);
  logic [PINS_PER_GROUP-1:0] change;
  logic                      flag_q;

  for (genvar p = 0; p < PINS_PER_GROUP; p++) begin : g_pin
    change_sense_pin_sync3 u_sync (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .pin_i      (pins_i[p]),
      .level_o    (),
      .change_o   (change[p])
    );
  end

  // Masked-off pins never reach the flag
  assign set_o = group_en_i && |(change & mask_i);

  // ------------------------------------------------------------
  // Sticky flag, set wins over clear
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      flag_q <= 1'b0;
    end else if (set_o) begin
      flag_q <= 1'b1;
    end else if (clear_i) begin
      flag_q <= 1'b0;
    end
  end

  assign flag_o = flag_q;
endmodule : change_sense_pin_group

// ---- hw/change_sense_pin_unit.sv ----
// Pin change interrupt unit top: Avalon-MM register file and four pin groups.
// Assumes pins are asynchronous; one core clock; vector-taken pulses from the CPU.
//
// Behaviour
// - Enabled change on pins 16-23 sets flag 2
// - Enabled change on pins 8-15 sets flag 1
// - Enabled change on pins 0-7 sets flag 0
// - Flag with global and group enable requests vector
// - Taking the vector clears its group flag
// - Writing one clears flag; zero leaves it
// - Group-3 mask, pin enabled with group enable
// - Zero mask bit blocks that pin's changes
// - Group-2 mask for pins 23-16, gated by enable
// - Group-1 mask for pins 15-8, gated by enable
// - Group-0 mask for pins 7-0, gated by enable
// - Enabled change on pins 24-31 sets flag 3
// - Control register holds one enable per group
`timescale 1ns/1ns
module change_sense_pin_unit
  import change_sense_pin_pkg::*;
(
  input  wire logic              core_clk_i,
  input  wire logic              arst_n_i,
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [3:0]        avs_byteenable_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic [31:0]            avs_readdata_o,
  output logic                   avs_waitrequest_o,
  input  wire logic [PINS-1:0]   change_sense_pin_i,
  input  wire logic [GROUPS-1:0] vector_taken_i,
  output logic [GROUPS-1:0]      vector_request_o,
  output logic                   irq_o
);

  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  change_sense_pin_avm_req_t   req;
  change_sense_pin_bus_state_t state_q;
  logic             wr_ok;
  logic             rd_ok;
  logic [7:0]       idx;
  logic             word_ok;
  logic [31:0]      rdata_d;
  logic [31:0]      rdata_q;

  assign req.address    = avs_address_i;
  assign req.read       = avs_read_i;
  assign req.write      = avs_write_i;
  assign req.byteenable = avs_byteenable_i;
  assign req.writedata  = avs_writedata_i;

  assign idx     = req.address[ADDR_W-1:2];
  assign word_ok = req.address[1:0] == 2'h0;

  // One wait state: the access completes in the acknowledge cycle
  assign avs_waitrequest_o = !(state_q == BUS_ACK);
  assign wr_ok = req.write && state_q == BUS_ACK && req.byteenable[0] && word_ok;
  assign rd_ok = req.read && state_q == BUS_ACK;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state_q <= BUS_IDLE;
    end else begin
      case (state_q)
        BUS_IDLE: begin
          if (req.read || req.write) begin
            state_q <= BUS_ACK;
          end
        end
        BUS_ACK: state_q <= BUS_IDLE;
        default: state_q <= BUS_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  logic [7:0]        mask_q [GROUPS];
  logic [GROUPS-1:0] group_en_q;
  logic              global_en_q;
  logic [GROUPS-1:0] irq_mask_q;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      for (int g = 0; g < GROUPS; g++) begin
        mask_q[g] <= MASK_RESET;
      end
    end else if (wr_ok) begin
      case (idx)
        IDX_GROUP0_PIN_MASK: mask_q[0] <= req.writedata[7:0];
        IDX_GROUP1_PIN_MASK: mask_q[1] <= req.writedata[7:0];
        IDX_GROUP2_PIN_MASK: mask_q[2] <= req.writedata[7:0];
        IDX_GROUP3_PIN_MASK: mask_q[3] <= req.writedata[7:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      group_en_q  <= FLAG_RESET;
      global_en_q <= 1'b0;
      irq_mask_q  <= FLAG_RESET;
    end else if (wr_ok) begin
      case (idx)
        IDX_GROUP_ENABLE:  group_en_q  <= req.writedata[GROUPS-1:0];
        IDX_GLOBAL_ENABLE: global_en_q <= req.writedata[GLOBAL_EN_BIT];
        IDX_IRQ_MASK:      irq_mask_q  <= req.writedata[GROUPS-1:0];
        default: ;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Pin groups
  // ------------------------------------------------------------
  logic [GROUPS-1:0] flag;
  logic [GROUPS-1:0] set_ev;
  logic [GROUPS-1:0] flag_clr;
  logic [GROUPS-1:0] w1c;

  // Write-one clears; a zero bit leaves the flag alone
  assign w1c = (wr_ok && idx == IDX_PIN_CHANGE_FLAGS) ? req.writedata[GROUPS-1:0] : FLAG_RESET;
  assign flag_clr = w1c | vector_taken_i;

  for (genvar g = 0; g < GROUPS; g++) begin : g_grp
    change_sense_pin_group u_group (
      .core_clk_i (core_clk_i),
      .arst_n_i   (arst_n_i),
      .pins_i     (change_sense_pin_i[g*PINS_PER_GROUP +: PINS_PER_GROUP]),
      .mask_i     (mask_q[g]),
      .group_en_i (group_en_q[g]),
      .clear_i    (flag_clr[g]),
      .flag_o     (flag[g]),
      .set_o      (set_ev[g])
    );
  end

  // Vector request needs flag, group enable and global enable
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vector_request_o <= FLAG_RESET;
    end else begin
      vector_request_o <= flag & group_en_q & {GROUPS{global_en_q}} & ~flag_clr;
    end
  end

  // ------------------------------------------------------------
  // Interrupt status: sticky, cleared by reading
  // ------------------------------------------------------------
  logic [GROUPS-1:0] irq_status_q;
  logic              status_rd;

  assign status_rd = rd_ok && idx == IDX_IRQ_STATUS;

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_status_q <= FLAG_RESET;
    end else begin
      // Events landing in the read cycle survive the clear
      irq_status_q <= (status_rd ? FLAG_RESET : irq_status_q) | set_ev;
    end
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(((status_rd ? FLAG_RESET : irq_status_q) | set_ev) & irq_mask_q);
    end
  end

  // ------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------
  always_comb begin
    rdata_d = UNMAPPED_READ;
    case (idx)
      IDX_GROUP0_PIN_MASK:  rdata_d[7:0]          = mask_q[0];
      IDX_GROUP1_PIN_MASK:  rdata_d[7:0]          = mask_q[1];
      IDX_GROUP2_PIN_MASK:  rdata_d[7:0]          = mask_q[2];
      IDX_GROUP3_PIN_MASK:  rdata_d[7:0]          = mask_q[3];
      IDX_PIN_CHANGE_FLAGS: rdata_d[GROUPS-1:0]   = flag;
      IDX_GROUP_ENABLE:     rdata_d[GROUPS-1:0]   = group_en_q;
      IDX_GLOBAL_ENABLE:    rdata_d[GLOBAL_EN_BIT] = global_en_q;
      IDX_IRQ_STATUS:       rdata_d[GROUPS-1:0]   = irq_status_q;
      IDX_IRQ_MASK:         rdata_d[GROUPS-1:0]   = irq_mask_q;
      default:              rdata_d               = UNMAPPED_READ;
    endcase
  end

  // Data captured on the request edge, presented with the acknowledge
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata_q <= UNMAPPED_READ;
    end else if (state_q == BUS_IDLE && req.read) begin
      rdata_q <= rdata_d;
    end
  end

  assign avs_readdata_o = rdata_q;

endmodule : change_sense_pin_unit

// ---- test/change_sense_pin_unit_chk.sv ----
// Checker for the pin change unit: bus timing and request behaviour.
// Assumes it is bound to change_sense_pin_unit and sees only its ports.
`timescale 1ns/1ns
module change_sense_pin_unit_chk
  import change_sense_pin_pkg::*;
(
  input wire logic              core_clk_i,
  input wire logic              arst_n_i,
  input wire logic [ADDR_W-1:0] avs_address_i,
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [3:0]        avs_byteenable_i,
  input wire logic [31:0]       avs_writedata_i,
  input wire logic [31:0]       avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  input wire logic [PINS-1:0]   change_sense_pin_i,
  input wire logic [GROUPS-1:0] vector_taken_i,
  input wire logic [GROUPS-1:0] vector_request_o,
  input wire logic              irq_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [PINS-1:0] pin_q;
  logic [3:0]      quiet_q;
  logic [3:0]      wr_q;
  // ------------------------------------------------------------
  // Age counters; writes can raise requests without a pin change
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pin_q   <= '0;
      quiet_q <= 4'h0;
      wr_q    <= 4'h0;
    end else begin
      pin_q   <= change_sense_pin_i;
      quiet_q <= (pin_q != change_sense_pin_i) ? 4'h0 : (quiet_q == 4'hf ? 4'hf : quiet_q + 4'h1);
      wr_q    <= avs_write_i ? 4'h0 : (wr_q == 4'hf ? 4'hf : wr_q + 4'h1);
    end
  end
  a_wait_one: assert property ($rose(avs_read_i | avs_write_i) |=> !avs_waitrequest_o)
    else $error("bus answer not after one wait cycle");
  a_wait_once: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_idle_wait: assert property (!(avs_read_i || avs_write_i) |-> avs_waitrequest_o)
    else $error("waitrequest low while idle");
  a_rdata_hold: assert property (!avs_read_i |=> $stable(avs_readdata_o))
    else $error("read data changed without a read");
  a_unmapped_read: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i == 10'h000
    |-> avs_readdata_o == 32'h0) else $error("unmapped read not zero");
  a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data bits not zero");
  a_req_hold: assert property (wr_q > 4'h3 && vector_taken_i == 4'h0 |=>
    (vector_request_o & $past(vector_request_o)) == $past(vector_request_o)) else $error("request dropped");
  a_take_clear: assert property ((vector_taken_i & vector_request_o) != 4'h0 |=>
    (vector_request_o & $past(vector_taken_i)) == 4'h0) else $error("request stays after vector taken");
  a_no_spurious: assert property (wr_q > 4'h3 && ($rose(irq_o) ||
    (vector_request_o & ~$past(vector_request_o)) != 4'h0) |-> quiet_q < 4'h8)
    else $error("request or irq raised without a pin change");
endmodule : change_sense_pin_unit_chk

bind change_sense_pin_unit change_sense_pin_unit_chk u_chk (.core_clk_i, .arst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
  .avs_byteenable_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .change_sense_pin_i,
  .vector_taken_i, .vector_request_o, .irq_o);

// ---- test/change_sense_pin_pin_model.sv ----
// Model of the signals on the general-purpose input pins.
// Assumes the bench calls flip; pins start low, matching the reset level.
`timescale 1ns/1ns
module change_sense_pin_pin_model
  import change_sense_pin_pkg::*;
(
  input  wire logic        core_clk_i,
  output logic [PINS-1:0]  change_sense_pin_o
);
  initial change_sense_pin_o = '0;
  // Whole-cycle levels; shorter pulses may be missed by the synchroniser
  task automatic flip(input int p);
    @(posedge core_clk_i);
    change_sense_pin_o[p] <= ~change_sense_pin_o[p];
  endtask : flip
endmodule : change_sense_pin_pin_model

// ---- test/change_sense_pin_unit_tb_top.sv ----
// Self-checking bench for the pin change unit over Avalon-MM.
// Assumes the pin model and the bound checker are compiled with it.
`timescale 1ns/1ns
module change_sense_pin_unit_tb_top import change_sense_pin_pkg::*;;
  logic              core_clk_i = 1'b0;
  logic              arst_n_i   = 1'b0;
  logic [ADDR_W-1:0] adr        = '0;
  logic              rd_en      = 1'b0;
  logic              wr_en      = 1'b0;
  logic [31:0]       wdat       = '0;
  logic [31:0]       rdat;
  logic              wait_o;
  logic [PINS-1:0]   pins;
  logic [GROUPS-1:0] vt         = '0;
  logic [GROUPS-1:0] vreq;
  logic              irq;
  int                err_total  = 0;
  int                checks_done = 0;
  logic [7:0]        midx [4]   = '{IDX_GROUP0_PIN_MASK, IDX_GROUP1_PIN_MASK, IDX_GROUP2_PIN_MASK,
                                    IDX_GROUP3_PIN_MASK};
  always #20 core_clk_i = ~core_clk_i;
  change_sense_pin_unit u_dut (.core_clk_i(core_clk_i), .arst_n_i(arst_n_i), .avs_address_i(adr), .avs_read_i(rd_en),
    .avs_write_i(wr_en), .avs_byteenable_i(4'hf), .avs_writedata_i(wdat), .avs_readdata_o(rdat),
    .avs_waitrequest_o(wait_o), .change_sense_pin_i(pins), .vector_taken_i(vt), .vector_request_o(vreq),
    .irq_o(irq));
  change_sense_pin_pin_model u_pins (.core_clk_i(core_clk_i), .change_sense_pin_o(pins));
  task automatic print_verdict();
    if (err_total == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // Request held until the rising edge that sees waitrequest low; data taken there
  task automatic bus(input logic we, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] q);
    int n;
    @(posedge core_clk_i);
    adr   <= {idx, 2'b00};
    rd_en <= !we;
    wr_en <= we;
    wdat  <= {24'h0, wd};
    n = 0;
    do begin
      @(posedge core_clk_i);
      n++;
    end while (wait_o !== 1'b0 && n < 20);
    if (wait_o !== 1'b0) begin
      err_total++;
      print_verdict();
    end
    q = rdat;
    rd_en <= 1'b0;
    wr_en <= 1'b0;
  endtask : bus
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask : wr
  task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk($sformatf("register %h", idx), exp, q);
  endtask : rdchk
  task automatic settle(input int n);
    repeat (n) @(posedge core_clk_i);
    @(negedge core_clk_i);
  endtask : settle
  initial begin
    repeat (6) @(posedge core_clk_i);
    arst_n_i <= 1'b1;
    for (int i = 0; i < 4; i++) rdchk(midx[i], 32'h0);
    rdchk(IDX_PIN_CHANGE_FLAGS, 32'h0);
    wr(8'h00, 8'hff);
    rdchk(8'h00, 32'h0);
    wr(IDX_IRQ_MASK, 8'h0f);
    for (int g = 0; g < 4; g++) begin
      wr(midx[g], 8'h5a);
      rdchk(midx[g], 32'h5a);
      u_pins.flip(8 * g);
      settle(8);
      rdchk(IDX_PIN_CHANGE_FLAGS, 32'h0);
      u_pins.flip(8 * g + 1);
      settle(8);
      rdchk(IDX_PIN_CHANGE_FLAGS, 32'h0);
      wr(IDX_GROUP_ENABLE, 8'(1 << g));
      u_pins.flip(8 * g + 1);
      settle(8);
      rdchk(IDX_PIN_CHANGE_FLAGS, 32'(1 << g));
      chk("vector_request", 32'h0, 32'(vreq));
      chk("irq", 32'h1, 32'(irq));
      rdchk(IDX_IRQ_STATUS, 32'(1 << g));
      rdchk(IDX_IRQ_STATUS, 32'h0);
      settle(2);
      chk("irq", 32'h0, 32'(irq));
      wr(IDX_GLOBAL_ENABLE, 8'h01);
      settle(3);
      chk("vector_request", 32'(1 << g), 32'(vreq));
      wr(IDX_PIN_CHANGE_FLAGS, 8'h00);
      rdchk(IDX_PIN_CHANGE_FLAGS, 32'(1 << g));
      wr(IDX_PIN_CHANGE_FLAGS, 8'(1 << g));
      rdchk(IDX_PIN_CHANGE_FLAGS, 32'h0);
      chk("vector_request", 32'h0, 32'(vreq));
      u_pins.flip(8 * g + 6);
      settle(8);
      chk("vector_request", 32'(1 << g), 32'(vreq));
      @(posedge core_clk_i);
      vt <= 4'(1 << g);
      @(posedge core_clk_i);
      vt <= 4'h0;
      settle(2);
      chk("vector_request", 32'h0, 32'(vreq));
      rdchk(IDX_PIN_CHANGE_FLAGS, 32'h0);
      wr(IDX_GLOBAL_ENABLE, 8'h00);
      wr(IDX_GROUP_ENABLE, 8'h00);
      rdchk(IDX_IRQ_STATUS, 32'(1 << g));
    end
    wr(IDX_IRQ_MASK, 8'h00);
    wr(IDX_GROUP_ENABLE, 8'h01);
    u_pins.flip(1);
    settle(8);
    chk("irq", 32'h0, 32'(irq));
    rdchk(IDX_IRQ_STATUS, 32'h1);
    print_verdict();
  end
endmodule : change_sense_pin_unit_tb_top
